// [src/bmc_defs.svh]
`ifndef BMC_DEFS_SVH
`define BMC_DEFS_SVH

// register byte offsets
`define BMC_CTRL_OFS 8'h00
`define BMC_KPB_OFS 8'h04
`define BMC_UDB_OFS 8'h08
`define BMC_IST_OFS 8'h0c
`define BMC_IMSK_OFS 8'h10

// control field positions
`define BMC_FETCH_BIT 16
`define BMC_CDATA_BIT 17
`define BMC_DMA_BIT 18
`define BMC_DEBUG_BIT 19
`define BMC_SHARED_BIT 20
`define BMC_WAIT_BIT 6
`define BMC_ARB_LSB 0

// initiator indices into the fault vectors
`define BMC_INI_FETCH 0
`define BMC_INI_CDATA 1
`define BMC_INI_DMA 2
`define BMC_INI_DEBUG 3
`define BMC_INI_SHARED 4
`define BMC_NUM_INI 5

// arbitration codes
`define BMC_ARB_MODE0 3'h0
`define BMC_ARB_MODE1 3'h1
`define BMC_ARB_MODE2 3'h2

// reset values and writable masks
`define BMC_CTRL_RST 32'h001f0041
`define BMC_CTRL_MASK 32'h001f0047
`define BMC_BASE_RST 6'h00
`define BMC_BASE_LSB 10
`define BMC_IST_MASK 32'h0000001f

// ahb encodings
`define BMC_HSIZE_WORD 3'h2
`define BMC_HTRANS_NONSEQ 2'h2

`endif

// [src/bmc_pkg.sv]
package bmc_pkg;

    typedef struct packed {
        logic [4:0] fault_en;
        logic wait_sel;
        logic [2:0] arb;
    } bmc_ctrl_type;

    typedef struct packed {
        logic [5:0] kernel_prog;
        logic [5:0] user_data;
    } bmc_part_type;

    typedef enum logic [1:0] {
        BMC_ST_IDLE,
        BMC_ST_WRITE,
        BMC_ST_RDWAIT,
        BMC_ST_RDOUT
    } bmc_state_type;

endpackage : bmc_pkg

// [src/bmc_fault_gate.sv]
`timescale 1ns/100ps
`default_nettype none
module bmc_fault_gate (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // unmapped access from one initiator
    input wire logic unmapped,
    input wire logic enable,
    input wire logic suppress,
    // error response toward that initiator
    output logic fault_r
);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fault_r <= 1'b0;
        end else begin
            fault_r <= unmapped & enable & ~suppress;
        end
    end

endmodule : bmc_fault_gate
`default_nettype wire

// [src/bmc_cfg.sv]
// Design decisions made here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "bmc_defs.svh"
module bmc_cfg
    import bmc_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic [2:0] hsize,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // unmapped access strobes, one per initiator
    input wire logic [4:0] unmapped_access,
    input wire logic debug_mode,
    // bus error responses, one per initiator
    output logic [4:0] bus_fault,
    // cpu access to data ram
    input wire logic cpu_ram_req,
    output logic cpu_ram_ready,
    // configuration toward the matrix
    output logic [2:0] arb_mode_sel,
    output logic [31:0] kernel_program_base,
    output logic [31:0] user_data_base,
    // interrupt
    output logic irq
);

    bmc_ctrl_type ctrl_r;
    bmc_part_type part_r;
    bmc_state_type state_r;
    logic [31:0] hrdata_r;
    logic [7:0] ofs_r;
    logic word_r;
    logic [4:0] ist_r;
    logic [4:0] imsk_r;
    logic setup_r;
    logic accept;
    logic wr_commit;
    logic rd_capture;
    logic ist_clear;
    logic [4:0] suppress;
    logic [31:0] ctrl_word;

    function automatic logic [31:0] base_word(input logic [5:0] b);
        base_word = {16'h0000, b, 10'h000};
    endfunction : base_word

    function automatic logic [31:0] ctrl_pack(input bmc_ctrl_type c);
        logic [31:0] w;
        w = 32'h00000000;
        w[`BMC_FETCH_BIT +: 5] = c.fault_en;
        w[`BMC_WAIT_BIT] = c.wait_sel;
        w[`BMC_ARB_LSB +: 3] = c.arb;
        ctrl_pack = w & `BMC_CTRL_MASK;
    endfunction : ctrl_pack

    function automatic logic [2:0] arb_decode(input logic [2:0] code);
        case (code)
            `BMC_ARB_MODE0: arb_decode = 3'h1;
            `BMC_ARB_MODE1: arb_decode = 3'h2;
            `BMC_ARB_MODE2: arb_decode = 3'h4;
            default: arb_decode = 3'h0;
        endcase
    endfunction : arb_decode

    assign ctrl_word = ctrl_pack(ctrl_r);

    // bus handshake
    assign accept = hsel & htrans[1] & hready;
    assign hreadyout = (state_r != BMC_ST_RDWAIT);
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;
    assign wr_commit = (state_r == BMC_ST_WRITE) & word_r;
    assign rd_capture = (state_r == BMC_ST_RDWAIT);
    assign ist_clear = rd_capture & (ofs_r == `BMC_IST_OFS);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= BMC_ST_IDLE;
        end else begin
            case (state_r)
                BMC_ST_RDWAIT: begin
                    state_r <= BMC_ST_RDOUT;
                end
                BMC_ST_IDLE, BMC_ST_WRITE, BMC_ST_RDOUT: begin
                    if (accept && hwrite) begin
                        state_r <= BMC_ST_WRITE;
                    end else if (accept) begin
                        state_r <= BMC_ST_RDWAIT;
                    end else begin
                        state_r <= BMC_ST_IDLE;
                    end
                end
                default: begin
                    state_r <= BMC_ST_IDLE;
                end
            endcase
        end
    end

    // address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ofs_r <= 8'h00;
            word_r <= 1'b0;
        end else if (accept) begin
            ofs_r <= haddr[7:0];
            word_r <= (hsize == `BMC_HSIZE_WORD) && (haddr[1:0] == 2'h0);
        end
    end

    // read data, one wait state so writes just before are seen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h00000000;
        end else if (rd_capture) begin
            case (ofs_r)
                `BMC_CTRL_OFS: hrdata_r <= ctrl_word;
                `BMC_KPB_OFS: hrdata_r <= base_word(part_r.kernel_prog);
                `BMC_UDB_OFS: hrdata_r <= base_word(part_r.user_data);
                `BMC_IST_OFS: hrdata_r <= {27'h0000000, ist_r};
                `BMC_IMSK_OFS: hrdata_r <= {27'h0000000, imsk_r};
                default: hrdata_r <= 32'h00000000;
            endcase
        end
    end

    // control register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r.fault_en <= 5'(`BMC_CTRL_RST >> `BMC_FETCH_BIT);
            ctrl_r.wait_sel <= 1'(`BMC_CTRL_RST >> `BMC_WAIT_BIT);
            ctrl_r.arb <= `BMC_ARB_MODE1;
        end else if (wr_commit && ofs_r == `BMC_CTRL_OFS) begin
            ctrl_r.fault_en <= hwdata[`BMC_FETCH_BIT +: 5];
            ctrl_r.wait_sel <= hwdata[`BMC_WAIT_BIT];
            ctrl_r.arb <= hwdata[`BMC_ARB_LSB +: 3];
        end
    end

    // partition bases
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            part_r.kernel_prog <= `BMC_BASE_RST;
            part_r.user_data <= `BMC_BASE_RST;
        end else if (wr_commit) begin
            if (ofs_r == `BMC_KPB_OFS) begin
                part_r.kernel_prog <= hwdata[`BMC_BASE_LSB +: 6];
            end
            if (ofs_r == `BMC_UDB_OFS) begin
                part_r.user_data <= hwdata[`BMC_BASE_LSB +: 6];
            end
        end
    end

    assign kernel_program_base = base_word(part_r.kernel_prog);
    assign user_data_base = base_word(part_r.user_data);
    assign arb_mode_sel = arb_decode(ctrl_r.arb);

    // fault gating; cpu initiators are silenced in debug mode
    always_comb begin
        suppress = 5'h00;
        suppress[`BMC_INI_FETCH] = debug_mode;
        suppress[`BMC_INI_CDATA] = debug_mode;
    end

    genvar gi;
    generate
        for (gi = 0; gi < `BMC_NUM_INI; gi = gi + 1) begin : g_fault
            bmc_fault_gate u_gate (
                .hclk(hclk),
                .hresetn(hresetn),
                .unmapped(unmapped_access[gi]),
                .enable(ctrl_r.fault_en[gi]),
                .suppress(suppress[gi]),
                .fault_r(bus_fault[gi])
            );
        end
    endgenerate

    // sticky fault status, set wins over read clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ist_r <= 5'h00;
        end else if (ist_clear) begin
            ist_r <= bus_fault;
        end else begin
            ist_r <= ist_r | bus_fault;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            imsk_r <= 5'h00;
        end else if (wr_commit && ofs_r == `BMC_IMSK_OFS) begin
            imsk_r <= hwdata[4:0];
        end
    end

    assign irq = |(ist_r & imsk_r);

    // data ram address setup wait state
    assign cpu_ram_ready = cpu_ram_req & (~ctrl_r.wait_sel | setup_r);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            setup_r <= 1'b0;
        end else if (cpu_ram_ready) begin
            setup_r <= 1'b0;
        end else if (cpu_ram_req) begin
            setup_r <= 1'b1;
        end
    end

    AST_SHARED_FAULT: assert property (@(posedge hclk) disable iff (!hresetn)
        unmapped_access[`BMC_INI_SHARED] |=>
            bus_fault[`BMC_INI_SHARED] == $past(ctrl_r.fault_en[`BMC_INI_SHARED]))
        else $error("shared bus fault does not follow its enable");

    AST_DEBUG_FAULT: assert property (@(posedge hclk) disable iff (!hresetn)
        unmapped_access[`BMC_INI_DEBUG] |=>
            bus_fault[`BMC_INI_DEBUG] == $past(ctrl_r.fault_en[`BMC_INI_DEBUG]))
        else $error("debug unit fault does not follow its enable");

    AST_DMA_FAULT: assert property (@(posedge hclk) disable iff (!hresetn)
        unmapped_access[`BMC_INI_DMA] |=>
            bus_fault[`BMC_INI_DMA] == $past(ctrl_r.fault_en[`BMC_INI_DMA]))
        else $error("dma fault does not follow its enable");

    AST_CDATA_FAULT: assert property (@(posedge hclk) disable iff (!hresetn)
        unmapped_access[`BMC_INI_CDATA] |=> bus_fault[`BMC_INI_CDATA] ==
            ($past(ctrl_r.fault_en[`BMC_INI_CDATA]) && !$past(debug_mode)))
        else $error("cpu data fault wrong for enable or debug mode");

    AST_FETCH_FAULT: assert property (@(posedge hclk) disable iff (!hresetn)
        unmapped_access[`BMC_INI_FETCH] |=> bus_fault[`BMC_INI_FETCH] ==
            ($past(ctrl_r.fault_en[`BMC_INI_FETCH]) && !$past(debug_mode)))
        else $error("cpu fetch fault wrong for enable or debug mode");

    AST_NO_SPURIOUS: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 $rose(bus_fault[`BMC_INI_DMA]) |-> $past(unmapped_access[`BMC_INI_DMA]))
        else $error("bus fault without an unmapped access");

    AST_WAIT_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
        (cpu_ram_req && !ctrl_r.wait_sel) |-> cpu_ram_ready)
        else $error("wait state inserted while disabled");

    AST_WAIT_ONE: assert property (@(posedge hclk) disable iff (!hresetn)
        (cpu_ram_req && ctrl_r.wait_sel && !setup_r) |->
            !cpu_ram_ready ##1 (cpu_ram_ready || !cpu_ram_req))
        else $error("setup wait state not exactly one cycle");

    AST_ARB_MAP: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_r.arb == `BMC_ARB_MODE2) |-> (arb_mode_sel == 3'h4))
        else $error("arbitration code 010 does not select mode 2");

    AST_CTRL_RSV: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_r == BMC_ST_RDOUT && ofs_r == `BMC_CTRL_OFS) |->
            ((hrdata & ~`BMC_CTRL_MASK) == 32'h00000000))
        else $error("unimplemented control bits read nonzero");

    AST_KPB_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_commit && ofs_r == `BMC_KPB_OFS) |=>
            kernel_program_base[15:10] == $past(hwdata[15:10]))
        else $error("kernel program base not updated from write data");

    AST_BASE_LOW: assert property (@(posedge hclk) disable iff (!hresetn)
        (kernel_program_base[9:0] == 10'h000) && (user_data_base[9:0] == 10'h000)
            && (user_data_base[31:16] == 16'h0000))
        else $error("partition base low or high bits nonzero");

    AST_UDB_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_commit && ofs_r == `BMC_UDB_OFS) |=>
            user_data_base[15:10] == $past(hwdata[15:10]))
        else $error("user data base not updated from write data");

    AST_CTRL_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_commit && ofs_r == `BMC_CTRL_OFS) |=>
            ctrl_word == ($past(hwdata) & `BMC_CTRL_MASK))
        else $error("control readback differs from masked write data");

    AST_DEBUG_SILENT: assert property (@(posedge hclk) disable iff (!hresetn)
        debug_mode |=>
            (!bus_fault[`BMC_INI_CDATA] && !bus_fault[`BMC_INI_FETCH]))
        else $error("cpu fault raised in debug mode");

    AST_FAULT_GATED: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 ((bus_fault & ~$past(ctrl_r.fault_en)) == 5'h00))
        else $error("bus fault raised while its enable was clear");

    AST_ARB_MODE0: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_r.arb == `BMC_ARB_MODE0) |-> (arb_mode_sel == 3'h1))
        else $error("arbitration code 000 does not select mode 0");

    AST_ARB_MODE1: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_r.arb == `BMC_ARB_MODE1) |-> (arb_mode_sel == 3'h2))
        else $error("arbitration code 001 does not select mode 1");

endmodule : bmc_cfg
`default_nettype wire

// [tb/bmc_initiator_model.sv]
`timescale 1ns/100ps
`default_nettype none
module bmc_initiator_model (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // unmapped access strobes
    output logic [4:0] unmapped_access,
    // cpu access to data ram
    output logic cpu_ram_req,
    input wire logic cpu_ram_ready
);
    initial begin
        unmapped_access = 5'h00;
        cpu_ram_req = 1'b0;
    end

    // one-cycle strobe; caller stands just after a rising edge
    task automatic pulse(input logic [4:0] which);
        unmapped_access <= which;
        @(posedge hclk);
        unmapped_access <= 5'h00;
    endtask : pulse

    // request held until ready is seen at a rising edge; counts stall cycles
    task automatic ram_access(output int waits);
        logic rdy;
        waits = 0;
        cpu_ram_req <= 1'b1;
        forever begin
            @(negedge hclk);
            rdy = cpu_ram_ready;
            if (rdy === 1'b1 || waits > 8) break;
            waits++;
        end
        @(posedge hclk);
        cpu_ram_req <= 1'b0;
        @(posedge hclk);
    endtask : ram_access
endmodule : bmc_initiator_model
`default_nettype wire

// [tb/test_bus_matrix_config_ram_partition.sv]
`timescale 1ns/100ps
`default_nettype none
`include "bmc_defs.svh"
module test_bus_matrix_config_ram_partition;
    logic hclk, hresetn, hsel, hwrite, debug_mode;
    logic [31:0] haddr, hwdata, rdv;
    logic [1:0] htrans;
    logic [2:0] hsize;
    wire logic [31:0] hrdata, kernel_program_base, user_data_base;
    wire logic hreadyout, hresp, cpu_ram_req, cpu_ram_ready, irq;
    wire logic [4:0] unmapped_access, bus_fault;
    wire logic [2:0] arb_mode_sel;
    int failures = 0;
    int comparisons = 0;

    bmc_cfg u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hsize(hsize), .hwrite(hwrite), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .unmapped_access(unmapped_access), .debug_mode(debug_mode), .bus_fault(bus_fault),
        .cpu_ram_req(cpu_ram_req), .cpu_ram_ready(cpu_ram_ready),
        .arb_mode_sel(arb_mode_sel), .kernel_program_base(kernel_program_base),
        .user_data_base(user_data_base), .irq(irq));

    bmc_initiator_model u_ini (.hclk(hclk), .hresetn(hresetn),
        .unmapped_access(unmapped_access), .cpu_ram_req(cpu_ram_req),
        .cpu_ram_ready(cpu_ram_ready));

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic test_done;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done

    // waits for hready high at a rising edge; keeps read data of that edge
    task automatic wait_ready(output logic [31:0] rd);
        logic r;
        int n;
        n = 0;
        do begin
            @(negedge hclk);
            r = hreadyout;
            rd = hrdata;
            @(posedge hclk);
            n++;
        end while (r !== 1'b1 && n < 50);
        if (r !== 1'b1) check(1'b0, 1'b1, "hready timeout");
    endtask : wait_ready

    task automatic ahb(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
                       output logic [31:0] rd);
        logic [31:0] dummy;
        hsel <= 1'b1;
        htrans <= `BMC_HTRANS_NONSEQ;
        haddr <= {24'h0, ofs};
        hwrite <= wr;
        hsize <= `BMC_HSIZE_WORD;
        wait_ready(dummy);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready(rd);
    endtask : ahb

    task automatic rd_chk(input logic [7:0] ofs, input logic [31:0] exp, input string what);
        ahb(1'b0, ofs, 32'h0, rdv);
        check(rdv, exp, what);
    endtask : rd_chk

    task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
        ahb(1'b1, ofs, d, rdv);
    endtask : wr

    task automatic t_reset_values;
        rd_chk(`BMC_CTRL_OFS, 32'h001f0041, "control reset");
        rd_chk(`BMC_KPB_OFS, 32'h0, "kernel base reset");
        rd_chk(`BMC_UDB_OFS, 32'h0, "user base reset");
        rd_chk(8'h14, 32'h0, "unmapped offset");
        check(arb_mode_sel, 3'b010, "default arbitration");
        check(hresp, 1'b0, "okay response");
    endtask : t_reset_values

    task automatic t_ctrl_bits;
        wr(`BMC_CTRL_OFS, 32'hfffffff8);
        rd_chk(`BMC_CTRL_OFS, 32'h001f0040, "unimplemented bits");
        for (int c = 2; c >= 0; c--) begin
            wr(`BMC_CTRL_OFS, {29'h0000_0008, 3'(c)});
            rd_chk(`BMC_CTRL_OFS, {29'h0000_0008, 3'(c)}, "arb readback");
            check(arb_mode_sel, 3'b001 << c, "arb select");
        end
    endtask : t_ctrl_bits

    task automatic t_bases;
        wr(`BMC_KPB_OFS, 32'hffff0bff);
        rd_chk(`BMC_KPB_OFS, 32'h00000800, "kernel base");
        check(kernel_program_base, 32'h00000800, "kernel base out");
        wr(`BMC_UDB_OFS, 32'hffff17ff);
        rd_chk(`BMC_UDB_OFS, 32'h00001400, "user base");
        check(user_data_base, 32'h00001400, "user base out");
    endtask : t_bases

    task automatic fault(input logic [4:0] which, input logic [4:0] exp, input string what);
        u_ini.pulse(which);
        @(negedge hclk);
        check(bus_fault, exp, what);
        @(posedge hclk);
    endtask : fault

    task automatic t_faults;
        wr(`BMC_CTRL_OFS, 32'h001f0041);
        for (int i = 0; i < 5; i++) fault(5'h01 << i, 5'h01 << i, "enabled fault");
        wr(`BMC_CTRL_OFS, 32'h00000041);
        fault(5'h1f, 5'h00, "disabled faults");
        wr(`BMC_CTRL_OFS, 32'h001f0041);
        debug_mode <= 1'b1;
        fault(5'h1f, 5'h1c, "debug suppress");
        debug_mode <= 1'b0;
    endtask : t_faults

    task automatic t_irq;
        wr(`BMC_IMSK_OFS, 32'h4);
        ahb(1'b0, `BMC_IST_OFS, 32'h0, rdv);
        rd_chk(`BMC_IST_OFS, 32'h0, "status cleared");
        fault(5'h04, 5'h04, "dma fault");
        @(negedge hclk);
        check(irq, 1'b1, "irq raised");
        @(posedge hclk);
        rd_chk(`BMC_IST_OFS, 32'h4, "status dma");
        check(irq, 1'b0, "irq cleared");
        fault(5'h01, 5'h01, "fetch fault");
        @(negedge hclk);
        check(irq, 1'b0, "irq masked");
        @(posedge hclk);
        rd_chk(`BMC_IST_OFS, 32'h1, "status fetch");
    endtask : t_irq

    task automatic t_ram_wait;
        int w;
        wr(`BMC_CTRL_OFS, 32'h001f0041);
        u_ini.ram_access(w);
        check(w, 1, "one wait state");
        wr(`BMC_CTRL_OFS, 32'h001f0001);
        u_ini.ram_access(w);
        check(w, 0, "zero wait states");
    endtask : t_ram_wait

    initial begin
        #20000;
        failures++;
        test_done();
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        hwrite = 1'b0;
        hwdata = 32'h0;
        debug_mode = 1'b0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset_values();
        t_ctrl_bits();
        t_bases();
        t_faults();
        t_irq();
        t_ram_wait();
        test_done();
    end
endmodule : test_bus_matrix_config_ram_partition
`default_nettype wire
